// File: hw/iep_pkg.sv
// constants shared by the interrupt and exception prioritizer
// assumes a 25 MHz core clock and core-side fault strobes on that clock
package iep_pkg;

    // ranks of the priority ladder
    localparam logic [3:0] RANK_SMI   = 4'h0;
    localparam logic [3:0] RANK_PREV  = 4'h1;
    localparam logic [3:0] RANK_NEXT  = 4'h2;
    localparam logic [3:0] RANK_NMI   = 4'h3;
    localparam logic [3:0] RANK_MASKABLE_INT_REQ  = 4'h4;
    localparam logic [3:0] RANK_FETCH = 4'h5;
    localparam logic [3:0] RANK_DEC   = 4'h6;
    localparam logic [3:0] RANK_WAIT  = 4'h7;
    localparam logic [3:0] RANK_ESC   = 4'h8;
    localparam logic [3:0] RANK_CERR  = 4'h9;
    localparam logic [3:0] RANK_SEG   = 4'ha;
    localparam logic [3:0] RANK_PAGE  = 4'hb;
    localparam logic [3:0] RANK_ALIGN = 4'hc;
    localparam logic [3:0] RANK_NONE  = 4'hf;

    // vector numbers
    localparam logic [7:0] VEC_NONE  = 8'h00;
    localparam logic [7:0] VEC_DEBUG = 8'h01;
    localparam logic [7:0] VEC_NMI   = 8'h02;
    localparam logic [7:0] VEC_UD    = 8'h06;
    localparam logic [7:0] VEC_DNA   = 8'h07;
    localparam logic [7:0] VEC_DF    = 8'h08;
    localparam logic [7:0] VEC_TSS   = 8'h0a;
    localparam logic [7:0] VEC_NP    = 8'h0b;
    localparam logic [7:0] VEC_SS    = 8'h0c;
    localparam logic [7:0] VEC_GP    = 8'h0d;
    localparam logic [7:0] VEC_PF    = 8'h0e;
    localparam logic [7:0] VEC_MF    = 8'h10;
    localparam logic [7:0] VEC_AC    = 8'h11;

    // fault kind codes on the fetch and operand kind ports
    localparam logic [1:0] FK_NP  = 2'h0;
    localparam logic [1:0] FK_SS  = 2'h1;
    localparam logic [1:0] FK_GP  = 2'h2;
    localparam logic [1:0] FK_PF  = 2'h3; // fetch port only
    localparam logic [1:0] FK_IDT = 2'h3; // operand port: table limit

    // error code field positions
    localparam int EC_INDEX_LSB = 3;
    localparam int EC_S2_BIT    = 2;
    localparam int EC_S1_BIT    = 1;
    localparam int EC_S0_BIT    = 0;
    localparam logic [15:0] EC_RESET = 16'h0000;

    // pin synchroniser width: mgmt, nmi, maskable, coprocessor error
    // reset to each pin's idle level so no false nmi edge follows reset
    localparam int SYNC_W = 4;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 4'h9;

    // management input qualification
    localparam int CLK_PERIOD_NS = 40;
    localparam int DRC_PERIOD_NS = CLK_PERIOD_NS / 2;
    localparam int SMI_MIN_DRC   = 4;
    localparam int SMI_MIN_NS    = SMI_MIN_DRC * DRC_PERIOD_NS;
    localparam int SMI_MIN_CYC_I =
        (SMI_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SMI_MIN_CYC = 3'(SMI_MIN_CYC_I);
    localparam logic [2:0] SMI_CNT_RESET = 3'h0;

endpackage : iep_pkg

// File: hw/iep_prioritizer.sv
// interrupt and exception prioritizer with vector and error code forming
// assumes fault strobes and flags come from core logic on clk_i; the
// interrupt pins are asynchronous and are synchronised here
`timescale 1ns/10ps
module iep_prioritizer
    import iep_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        boundary_i,
    input  wire logic        sys_mgmt_int_n_i,
    input  wire logic        nmi_i,
    input  wire logic        maskable_int_req_i,
    input  wire logic        coproc_error_n_i,
    input  wire logic [7:0]  int_vector_i,
    input  wire logic        int_enable_flag_i,
    input  wire logic        real_mode_i,
    input  wire logic        resume_i,
    input  wire logic        prev_debug_trap_i,
    input  wire logic        next_debug_trap_i,
    input  wire logic        fetch_fault_i,
    input  wire logic [1:0]  fetch_kind_i,
    input  wire logic        decode_fault_i,
    input  wire logic        wait_insn_i,
    input  wire logic        coproc_escape_insn_i,
    input  wire logic        task_switched_flag_i,
    input  wire logic        monitor_coproc_flag_i,
    input  wire logic        emulate_coproc_flag_i,
    input  wire logic        seg_fault_i,
    input  wire logic [1:0]  seg_kind_i,
    input  wire logic        page_fault_i,
    input  wire logic        align_fault_i,
    input  wire logic [15:0] fault_sel_i,
    input  wire logic        fault_idt_i,
    input  wire logic        fault_ext_i,
    input  wire logic        pf_protect_i,
    input  wire logic        pf_write_i,
    input  wire logic        pf_user_i,
    input  wire logic        tss_partial_i,
    output logic             take_o,
    output logic [3:0]       rank_o,
    output logic [7:0]       vector_o,
    output logic [15:0]      err_code_o,
    output logic             err_valid_o,
    output logic             sys_mgmt_entry_o,
    output logic             sys_mgmt_state_o,
    output logic             restartable_o
);

    typedef struct packed {
        logic [2:0]  smi_cnt;
        logic        smi_pend;
        logic        nmi_prev;
        logic        nmi_pend;
        logic        sys_mgmt_state;
        logic        take;
        logic [3:0]  rank;
        logic [7:0]  vector;
        logic [15:0] err;
        logic        errv;
        logic        entry;
        logic        restart;
    } iep_state_s;

    iep_state_s          r;
    iep_state_s          next_r;
    logic [SYNC_W-1:0]   pins;
    logic                smi_low;
    logic                nmi_s;
    logic                maskable_int_req_s;
    logic                cerr_s;

    // vector of a fetch or operand segment fault, real mode remapped
    function automatic logic [7:0] fault_vec(input logic [1:0] kind,
                                             input logic       operand,
                                             input logic       real_md);
        logic [7:0] v;
        v = VEC_GP;
        case (kind)
            FK_NP:   v = VEC_NP;
            FK_SS:   v = VEC_SS;
            FK_GP:   v = VEC_GP;
            default: v = operand ? (real_md ? VEC_DF : VEC_GP) : VEC_PF;
        endcase
        return v;
    endfunction : fault_vec

    // vectors that real mode never raises
    function automatic logic real_drop(input logic [7:0] v,
                                       input logic       real_md);
        return real_md && (v == VEC_TSS || v == VEC_NP || v == VEC_PF);
    endfunction : real_drop

    // error code for a vector, selector or page layout
    function automatic logic [15:0] err_of(input logic [7:0]  v,
                                           input logic [15:0] sel,
                                           input logic        int_descriptor_table,
                                           input logic        ext,
                                           input logic [2:0]  pf);
        logic [15:0] c;
        c = EC_RESET;
        if (v == VEC_PF)
        begin
            c[EC_S2_BIT] = pf[2];
            c[EC_S1_BIT] = pf[1];
            c[EC_S0_BIT] = pf[0];
        end
        else if (v != VEC_AC && v != VEC_DF)
        begin
            c[15:EC_INDEX_LSB] = sel[15:EC_INDEX_LSB];
            c[EC_S2_BIT] = int_descriptor_table ? 1'b0 : sel[EC_S2_BIT];
            c[EC_S1_BIT] = int_descriptor_table;
            c[EC_S0_BIT] = ext;
        end
        return c;
    endfunction : err_of

    // protected-mode vectors that carry an error code
    function automatic logic has_err(input logic [7:0] v,
                                     input logic       real_md);
        return !real_md && (v == VEC_DF || v == VEC_TSS || v == VEC_NP
            || v == VEC_SS || v == VEC_GP || v == VEC_PF
            || v == VEC_AC);
    endfunction : has_err

    // asynchronous pins pass two flip-flops
    iep_sync u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({sys_mgmt_int_n_i, nmi_i, maskable_int_req_i,
                   coproc_error_n_i}),
        .q_o     (pins)
    );

    assign smi_low = !pins[3];
    assign nmi_s   = pins[2];
    assign maskable_int_req_s  = pins[1];
    assign cerr_s  = !pins[0];

    // arbitration at the boundary, evaluated alongside execution
    always_comb
    begin
        logic [3:0]  rk;
        logic [7:0]  vc;
        logic [7:0]  fv;
        logic [7:0]  sv;
        logic        smi_set;
        logic        nmi_set;
        rk = RANK_NONE;
        vc = VEC_NONE;
        fv = fault_vec(fetch_kind_i, 1'b0, real_mode_i);
        sv = fault_vec(seg_kind_i, 1'b1, real_mode_i);
        next_r = r;
        next_r.take  = 1'b0;
        next_r.entry = 1'b0;
        // management input must be seen low long enough
        if (smi_low)
        begin
            next_r.smi_cnt = (r.smi_cnt == SMI_MIN_CYC) ? r.smi_cnt
                                                      : r.smi_cnt + 3'h1;
        end
        else
        begin
            next_r.smi_cnt = SMI_CNT_RESET;
        end
        smi_set = smi_low && (r.smi_cnt == SMI_MIN_CYC - 3'h1);
        nmi_set = nmi_s && !r.nmi_prev;
        next_r.nmi_prev = nmi_s;
        if (resume_i)
        begin
            next_r.sys_mgmt_state = 1'b0;
        end
        // priority ladder, first match wins
        if (r.smi_pend && !r.sys_mgmt_state)
        begin
            rk = RANK_SMI;
        end
        else if (prev_debug_trap_i)
        begin
            rk = RANK_PREV;
            vc = VEC_DEBUG;
        end
        else if (next_debug_trap_i)
        begin
            rk = RANK_NEXT;
            vc = VEC_DEBUG;
        end
        else if (r.nmi_pend)
        begin
            rk = RANK_NMI;
            vc = VEC_NMI;
        end
        else if (maskable_int_req_s && int_enable_flag_i)
        begin
            rk = RANK_MASKABLE_INT_REQ;
            vc = int_vector_i;
        end
        else if (fetch_fault_i && !real_drop(fv, real_mode_i))
        begin
            rk = RANK_FETCH;
            vc = fv;
        end
        else if (decode_fault_i)
        begin
            rk = RANK_DEC;
            vc = VEC_UD;
        end
        else if (wait_insn_i && task_switched_flag_i
                 && monitor_coproc_flag_i)
        begin
            rk = RANK_WAIT;
            vc = VEC_DNA;
        end
        else if (coproc_escape_insn_i
                 && (emulate_coproc_flag_i || task_switched_flag_i))
        begin
            rk = RANK_ESC;
            vc = VEC_DNA;
        end
        else if (cerr_s)
        begin
            rk = RANK_CERR;
            vc = VEC_MF;
        end
        else if (seg_fault_i && !real_drop(sv, real_mode_i))
        begin
            rk = RANK_SEG;
            vc = sv;
        end
        else if (page_fault_i && !real_mode_i)
        begin
            rk = RANK_PAGE;
            vc = VEC_PF;
        end
        else if (align_fault_i)
        begin
            rk = RANK_ALIGN;
            vc = VEC_AC;
        end
        // one winner per boundary; the rest wait for the retry
        if (boundary_i && rk != RANK_NONE)
        begin
            next_r.take    = 1'b1;
            next_r.rank    = rk;
            next_r.vector  = vc;
            next_r.err     = err_of(vc, fault_sel_i, fault_idt_i,
                                    fault_ext_i,
                                    {pf_protect_i, pf_write_i, pf_user_i});
            next_r.errv    = has_err(vc, real_mode_i);
            next_r.restart = !tss_partial_i;
            if (rk == RANK_SMI)
            begin
                next_r.entry    = 1'b1;
                next_r.sys_mgmt_state      = 1'b1;
                next_r.smi_pend = 1'b0;
            end
            if (rk == RANK_NMI)
            begin
                next_r.nmi_pend = 1'b0;
            end
        end
        // a new request beats a same-cycle clear; losers stay pending
        if (smi_set)
        begin
            next_r.smi_pend = 1'b1;
        end
        if (nmi_set)
        begin
            next_r.nmi_pend = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            r <= '{smi_cnt: SMI_CNT_RESET, rank: RANK_NONE,
                   vector: VEC_NONE, err: EC_RESET, restart: 1'b1,
                   default: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign take_o           = r.take;
    assign rank_o           = r.rank;
    assign vector_o         = r.vector;
    assign err_code_o       = r.err;
    assign err_valid_o      = r.errv;
    assign sys_mgmt_entry_o = r.entry;
    assign sys_mgmt_state_o = r.sys_mgmt_state;
    assign restartable_o    = r.restart;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // pending management interrupt wins and enters the mode
    smi_top_a: assert property (
        boundary_i && r.smi_pend && !r.sys_mgmt_state
        |=> take_o && rank_o == RANK_SMI && sys_mgmt_entry_o)
        else $error("management interrupt did not win");

    // nmi beats the maskable request
    nmi_over_maskable_int_req_a: assert property (
        boundary_i && r.nmi_pend && !(r.smi_pend && !r.sys_mgmt_state)
        && !prev_debug_trap_i && !next_debug_trap_i
        |=> take_o && rank_o == RANK_NMI && vector_o == VEC_NMI)
        else $error("nmi not taken at rank 3");

    // maskable request honoured only when enabled
    maskable_int_req_enable_a: assert property (
        take_o && rank_o == RANK_MASKABLE_INT_REQ
        |-> $past(int_enable_flag_i) && vector_o == $past(int_vector_i))
        else $error("maskable request taken while disabled");

    // nothing is taken without a boundary
    one_per_bound_a: assert property (
        !boundary_i |=> !take_o)
        else $error("exception reported off a boundary");

    // real mode never reports 10, 11 or 14
    real_vec_a: assert property (
        take_o && $past(real_mode_i)
        |-> vector_o != VEC_TSS && vector_o != VEC_NP
            && vector_o != VEC_PF && !err_valid_o)
        else $error("forbidden vector in real mode");

    // alignment check code is zero
    zero_code_a: assert property (
        take_o && vector_o == VEC_AC
        |-> err_code_o == EC_RESET && err_valid_o == !$past(real_mode_i))
        else $error("alignment check code not zero");

    // page fault code bits follow the access
    page_code_a: assert property (
        take_o && vector_o == VEC_PF
        |-> err_code_o[2:0]
            == $past({pf_protect_i, pf_write_i, pf_user_i}))
        else $error("page fault code wrong");

    // entry pulse coincides with the mode flag and stays one cycle
    smm_entry_a: assert property (
        sys_mgmt_entry_o |-> sys_mgmt_state_o && rank_o == RANK_SMI
        ##1 !sys_mgmt_entry_o)
        else $error("management entry inconsistent");

    // both device-not-available cases use vector 7
    dna_vec_a: assert property (
        take_o && (rank_o == RANK_WAIT || rank_o == RANK_ESC)
        |-> vector_o == VEC_DNA)
        else $error("device-not-available vector wrong");

    // restart flag mirrors the split task segment case
    restart_a: assert property (
        take_o |-> restartable_o == !$past(tss_partial_i))
        else $error("restart flag wrong");

endmodule : iep_prioritizer

// File: hw/iep_sync.sv
// two-stage synchroniser for the asynchronous interrupt pins
// assumes the pins are quiet levels; width comes from the package
`timescale 1ns/10ps
module iep_sync
    import iep_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [SYNC_W-1:0] d_i,
    output logic      [SYNC_W-1:0] q_o
);

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
    } iep_sync_s;

    iep_sync_s r;
    iep_sync_s next_r;

    // first stage feeds only the second stage
    always_comb
    begin
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
    end

    // resets to the idle level of each pin
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            r <= {SYNC_RESET, SYNC_RESET};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign q_o = r.s2;

endmodule : iep_sync

// File: sim/iep_src_model.sv
// pin source model: interrupt requesters and the coprocessor error line
// assumes request levels from the bench, changed on the clock edge
`timescale 1ns/10ps
module iep_src_model
#(
    parameter int SMI_HOLD = 3
)
(
    input  wire logic clk_i,
    input  wire logic smi_rq_i,
    input  wire logic nmi_rq_i,
    input  wire logic maskable_int_req_rq_i,
    input  wire logic cerr_rq_i,
    output logic      smi_n_o  = 1'b1,
    output logic      nmi_o    = 1'b0,
    output logic      maskable_int_req_o   = 1'b0,
    output logic      cerr_n_o = 1'b1
);
    int hold = 0;

    // pins follow requests one edge later; management low SMI_HOLD cycles
    always @(posedge clk_i)
    begin
        smi_n_o  <= !(smi_rq_i || hold > 0); // six double-rate periods
        hold     <= smi_rq_i ? SMI_HOLD - 1 : (hold > 0 ? hold - 1 : 0);
        nmi_o    <= nmi_rq_i;
        maskable_int_req_o   <= maskable_int_req_rq_i;
        cerr_n_o <= !cerr_rq_i;
    end
endmodule : iep_src_model

// File: sim/tb_top.sv
// self-checking bench for the interrupt and exception prioritizer
// assumes the package, the design and the pin source model are compiled
`timescale 1ns/10ps
module tb_top
    import iep_pkg::*;
;
    logic        clk_i, rst_n_i, bnd, smi_rq, ie, rm, resume;
    logic        ts, mp, em, int_descriptor_table, ext, pprot, pwr, pusr, tssp;
    logic [12:1] src;
    logic [1:0]  fk, sk;
    logic [7:0]  ivec, vec;
    logic [15:0] sel, ec;
    logic        smi_n, nmi, maskable_int_req, cerr_n;
    logic        take, entry, state, rstart, ev;
    logic [3:0]  rank;
    int          bad_count, n_checks;
    int          cyc = 0;

    iep_prioritizer u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .boundary_i(bnd),
        .sys_mgmt_int_n_i(smi_n), .nmi_i(nmi), .maskable_int_req_i(maskable_int_req),
        .coproc_error_n_i(cerr_n), .int_vector_i(ivec),
        .int_enable_flag_i(ie), .real_mode_i(rm), .resume_i(resume),
        .prev_debug_trap_i(src[1]), .next_debug_trap_i(src[2]),
        .fetch_fault_i(src[5]), .fetch_kind_i(fk),
        .decode_fault_i(src[6]), .wait_insn_i(src[7]),
        .coproc_escape_insn_i(src[8]), .task_switched_flag_i(ts),
        .monitor_coproc_flag_i(mp), .emulate_coproc_flag_i(em),
        .seg_fault_i(src[10]), .seg_kind_i(sk), .page_fault_i(src[11]),
        .align_fault_i(src[12]), .fault_sel_i(sel), .fault_idt_i(int_descriptor_table),
        .fault_ext_i(ext), .pf_protect_i(pprot), .pf_write_i(pwr),
        .pf_user_i(pusr), .tss_partial_i(tssp), .take_o(take),
        .rank_o(rank), .vector_o(vec), .err_code_o(ec),
        .err_valid_o(ev), .sys_mgmt_entry_o(entry),
        .sys_mgmt_state_o(state), .restartable_o(rstart));

    iep_src_model u_src (
        .clk_i(clk_i), .smi_rq_i(smi_rq), .nmi_rq_i(src[3]),
        .maskable_int_req_rq_i(src[4]), .cerr_rq_i(src[9]), .smi_n_o(smi_n),
        .nmi_o(nmi), .maskable_int_req_o(maskable_int_req), .cerr_n_o(cerr_n));

    // core clock, 40 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // cycle ceiling so a hang still ends in the report
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count = bad_count + 1;
            results();
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // one boundary pulse, then the selected event is judged
    task bound(input logic t, input logic [3:0] r, input logic [7:0] v);
        @(posedge clk_i) bnd <= 1'b1;
        @(posedge clk_i) bnd <= 1'b0;
        #1;
        chk(16'(take), 16'(t));
        if (t)
        begin
            chk(16'(rank), 16'(r));
            chk(16'(vec), 16'(v));
        end
    endtask : bound

    // a single source k alone, judged with its error code
    task one(input int k, input logic t, input logic [3:0] r,
             input logic [7:0] v, input logic e, input logic [15:0] c);
        @(posedge clk_i) src <= 12'h1 << (k - 1);
        repeat (4) @(posedge clk_i);
        bound(t, r, v);
        if (t)
            chk(16'(ev), 16'(e));
        if (t && e)
            chk(ec, c);
        @(posedge clk_i) src <= 12'h0;
    endtask : one

    // management request beats a pending nmi, then nmi follows
    task t_smi();
        @(posedge clk_i) smi_rq <= 1'b1;
        src <= 12'h004;
        @(posedge clk_i) smi_rq <= 1'b0;
        repeat (6) @(posedge clk_i);
        bound(1'b1, RANK_SMI, VEC_NONE);
        chk(16'(entry), 16'h1);
        chk(16'(state), 16'h1);
        @(posedge clk_i);
        #1;
        chk(16'(take), 16'h0);
        chk(16'(entry), 16'h0);
        bound(1'b1, RANK_NMI, VEC_NMI);
        @(posedge clk_i) resume <= 1'b1;
        src <= 12'h0;
        @(posedge clk_i) resume <= 1'b0;
        #1;
        chk(16'(state), 16'h0);
        $display("t_smi done");
    endtask : t_smi

    // all twelve src sources at once, management request not driven; each winner is withdrawn after its take
    task t_ladder();
        logic [7:0] lv [1:12];
        lv = '{VEC_DEBUG, VEC_DEBUG, VEC_NMI, 8'h40, VEC_GP, VEC_UD,
               VEC_DNA, VEC_DNA, VEC_MF, VEC_GP, VEC_PF, VEC_AC};
        @(posedge clk_i) {ts, mp} <= 2'b11;
        src <= 12'hfff;
        for (int k = 1; k <= 12; k++)
        begin
            repeat (4) @(posedge clk_i);
            bound(1'b1, 4'(k), lv[k]);
            @(posedge clk_i) src[k] <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        bound(1'b0, RANK_NONE, VEC_NONE);
        @(posedge clk_i) {ts, mp} <= 2'b00;
        $display("t_ladder done");
    endtask : t_ladder

    // maskable request only counts with the enable flag set
    task t_mask();
        @(posedge clk_i) ie <= 1'b0;
        one(4, 1'b0, RANK_MASKABLE_INT_REQ, 8'h40, 1'b0, 16'h0);
        @(posedge clk_i) ie <= 1'b1;
        one(4, 1'b1, RANK_MASKABLE_INT_REQ, 8'h40, 1'b0, 16'h0);
        $display("t_mask done");
    endtask : t_mask

    // protected mode error codes and the restart flag
    task t_codes();
        @(posedge clk_i) {pprot, pwr, pusr} <= 3'b101;
        one(11, 1'b1, RANK_PAGE, VEC_PF, 1'b1, 16'h0005);
        @(posedge clk_i) {pprot, pwr, pusr} <= 3'b010;
        one(11, 1'b1, RANK_PAGE, VEC_PF, 1'b1, 16'h0002);
        one(10, 1'b1, RANK_SEG, VEC_GP, 1'b1, 16'h1234);
        @(posedge clk_i) {int_descriptor_table, ext} <= 2'b11;
        one(10, 1'b1, RANK_SEG, VEC_GP, 1'b1, 16'h1233);
        @(posedge clk_i) tssp <= 1'b1;
        one(12, 1'b1, RANK_ALIGN, VEC_AC, 1'b1, 16'h0000);
        chk(16'(rstart), 16'h0);
        @(posedge clk_i) {tssp, int_descriptor_table, ext, pwr} <= 4'h0;
        one(6, 1'b1, RANK_DEC, VEC_UD, 1'b0, 16'h0);
        chk(16'(rstart), 16'h1);
        $display("t_codes done");
    endtask : t_codes

    // real mode vectors and the faults that never occur there
    task t_real();
        @(posedge clk_i) rm <= 1'b1;
        sk <= FK_IDT;
        one(10, 1'b1, RANK_SEG, VEC_DF, 1'b0, 16'h0);
        @(posedge clk_i) sk <= FK_SS;
        one(10, 1'b1, RANK_SEG, VEC_SS, 1'b0, 16'h0);
        @(posedge clk_i) sk <= FK_GP;
        one(10, 1'b1, RANK_SEG, VEC_GP, 1'b0, 16'h0);
        @(posedge clk_i) sk <= FK_NP;
        fk <= FK_PF;
        one(10, 1'b0, RANK_SEG, VEC_NP, 1'b0, 16'h0);
        one(11, 1'b0, RANK_PAGE, VEC_PF, 1'b0, 16'h0);
        one(5, 1'b0, RANK_FETCH, VEC_PF, 1'b0, 16'h0);
        @(posedge clk_i) rm <= 1'b0;
        one(5, 1'b1, RANK_FETCH, VEC_PF, 1'b1, 16'h0);
        @(posedge clk_i) {fk, sk} <= {FK_GP, FK_GP};
        $display("t_real done");
    endtask : t_real

    // device-not-available flag combinations
    task t_dna();
        @(posedge clk_i) em <= 1'b1;
        one(8, 1'b1, RANK_ESC, VEC_DNA, 1'b0, 16'h0);
        @(posedge clk_i) {em, ts} <= 2'b01;
        one(8, 1'b1, RANK_ESC, VEC_DNA, 1'b0, 16'h0);
        one(7, 1'b0, RANK_WAIT, VEC_DNA, 1'b0, 16'h0);
        @(posedge clk_i) ts <= 1'b0;
        one(8, 1'b0, RANK_ESC, VEC_DNA, 1'b0, 16'h0);
        $display("t_dna done");
    endtask : t_dna

    // reset, then the scenarios in turn
    initial
    begin
        bad_count = 0;
        n_checks = 0;
        {bnd, smi_rq, rm, resume, ts, mp, em, int_descriptor_table, ext} = '0;
        {pprot, pwr, pusr, tssp, rst_n_i} = '0;
        ie = 1'b1;
        src = 12'h0;
        {fk, sk} = {FK_GP, FK_GP};
        sel = 16'h1236;
        ivec = 8'h40;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // idle pins after reset must leave nothing pending
        repeat (2) @(posedge clk_i);
        bound(1'b0, RANK_NONE, VEC_NONE);
        chk(16'(rank), 16'(RANK_NONE));
        chk(16'(rstart), 16'h1);
        chk(16'(state), 16'h0);
        t_smi();
        t_ladder();
        t_mask();
        t_codes();
        t_real();
        t_dna();
        results();
    end
endmodule : tb_top
